// ### verilog/pml_consts.svh
`ifndef PML_CONSTS_SVH
`define PML_CONSTS_SVH

// Link widths
`define PML_DAL_W        16
`define PML_LINK_SIGS    14
`define PML_ALT_SIGS     5
// Cycle-type encoding on {write_byte_line_n, link_byte_select_n}
`define PML_ENC_RD       2'h3
`define PML_ENC_RDP      2'h2
`define PML_ENC_WR       2'h1
`define PML_ENC_WRB      2'h0
// Address hold after strobe, and master response wait limit
`define PML_HOLD_NS      50
`define PML_CLK_NS       25
`define PML_HOLD_CYC     ((`PML_HOLD_NS + `PML_CLK_NS - 1) / `PML_CLK_NS)
`define PML_SEL_WAIT     4'h8
`define PML_CNT_ONE      4'h1
`define PML_CNT_ZERO     4'h0

`endif

// ### verilog/pml_pkg.sv
`default_nettype none
package pml_pkg;
    typedef enum logic [1:0] {
        PML_WORD_WRITE_CYCLE = 2'h0,
        PML_BYTE_WRITE_CYCLE = 2'h1,
        PML_WORD_READ_CYCLE  = 2'h2,
        PML_READ_PAUSE_CYCLE = 2'h3
    } pml_cycle_t;
endpackage
`default_nettype wire

// ### verilog/pml_link_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "pml_consts.svh"
// Private memory link carried beside the shared bus; only the master drives
// the shared address/data wires (dal_m), the memory end only reads them.
interface pml_link_if;
    logic [15:0] dal_m;             // Address from master
    logic        dal_m_oe_n;        // Low while master drives
    logic        io_page_select_n;
    logic        write_byte_line_n;
    logic        link_byte_select_n;
    logic        link_cycle_strobe_n;
    logic        bus_sync_out_n;
    logic        bus_reply_in_n;
    logic        memory_selected_out_n;
    logic        alt_bus_memory_responding_n;
    modport master (
        output dal_m, dal_m_oe_n, io_page_select_n, write_byte_line_n,
               link_byte_select_n, link_cycle_strobe_n, bus_sync_out_n,
        input  bus_reply_in_n, memory_selected_out_n, alt_bus_memory_responding_n
    );
    modport memory (
        input  dal_m, dal_m_oe_n, io_page_select_n, write_byte_line_n,
               link_byte_select_n, link_cycle_strobe_n,
        output memory_selected_out_n
    );
endinterface
`default_nettype wire

// ### verilog/pml_memory_end.sv
`timescale 1ns/1ps
`default_nettype none
`include "pml_consts.svh"

// Summary of operation
// - Link is fourteen dedicated signals beside bus.
// - Only processor and memory use the link.
// - Address travels on shared address/data lines.
// - Word-read cycle supported.
// - Read-pause cycle supported for read-modify-write.
// - Word-write cycle supported.
// - Byte-write cycle supported, other byte kept.
// - Address phase identical for all cycle types.
// - Master drives address, page select, type lines.
// - Write-byte and byte-select encode cycle type.
// - Master holds address briefly after strobe.
// - Write-byte line has link-specific meaning.
// - Master never issues block-mode transfers.
// - Master does not snoop other masters' block transfers.
// - Five alternate-bus signals unused here.
// - Memory asserts selected after address received.
// - Master proceeds only when selected, no alt.
// - Selected dropped after strobe: ordinary cycle.
// - Strobe waits for prior sync, reply negation.
module pml_memory_end #(
    parameter logic [15:0] BASE_PAGE = 16'h0000  // Address bits [15:14] match
) (
    input  wire logic         sys_clk_i,
    input  wire logic         arst_n_i,
    pml_link_if.memory        link,
    output logic              cycle_valid_o,
    output logic [15:0]       cycle_addr_o,
    output logic              cycle_io_page_o,
    output pml_pkg::pml_cycle_t cycle_type_o,
    output logic              byte_high_o
);
    // ==========================================================
    // State
    typedef struct packed {
        logic [1:0]  strb_sync;
        logic [1:0]  sel_sync;
        logic [15:0] addr_s0;
        logic [15:0] addr_s1;
        logic [2:0]  ctl_s0;
        logic [2:0]  ctl_s1;
        logic        strobe_d;
        logic        sel_n;
        logic        valid;
        logic [15:0] addr;
        logic        iop;
        pml_pkg::pml_cycle_t ctype;
    } pml_mem_st_t;

    pml_mem_st_t st;
    pml_mem_st_t next_st;

    // Decode of the two active-low type lines
    function automatic pml_pkg::pml_cycle_t pml_decode(input logic [1:0] enc);
        pml_decode = pml_pkg::PML_WORD_READ_CYCLE;
        if (enc == `PML_ENC_RDP) begin
            pml_decode = pml_pkg::PML_READ_PAUSE_CYCLE;
        end else if (enc == `PML_ENC_WR) begin
            pml_decode = pml_pkg::PML_WORD_WRITE_CYCLE;
        end else if (enc == `PML_ENC_WRB) begin
            pml_decode = pml_pkg::PML_BYTE_WRITE_CYCLE;
        end
    endfunction

    // ==========================================================
    // Next state; all pins pass two flops, address phase sampled the
    // same way for every type so decode only happens at capture
    always_comb begin
        next_st = st;
        next_st.strb_sync = {st.strb_sync[0], ~link.link_cycle_strobe_n};
        next_st.sel_sync  = {st.sel_sync[0], ~link.dal_m_oe_n};
        next_st.addr_s0   = link.dal_m;
        next_st.addr_s1   = st.addr_s0;
        next_st.ctl_s0    = {~link.io_page_select_n, link.write_byte_line_n, link.link_byte_select_n};
        next_st.ctl_s1    = st.ctl_s0;
        next_st.strobe_d  = st.strb_sync[1];
        // Address seen and in our page: answer selected
        if (st.sel_sync[1] && !st.strb_sync[1]) begin
            next_st.sel_n = ~(st.addr_s1[15:14] == BASE_PAGE[15:14]);
        end else if (!st.sel_sync[1] && !st.strb_sync[1]) begin
            next_st.sel_n = 1'b1;
        end
        // Capture at strobe rise; master removes lines shortly after
        if (st.strb_sync[1] && !st.strobe_d && !st.sel_n) begin
            next_st.valid = 1'b1;
            next_st.addr  = st.addr_s1;
            next_st.iop   = st.ctl_s1[2];
            next_st.ctype = pml_decode(st.ctl_s1[1:0]);
        end else if (!st.strb_sync[1]) begin
            next_st.valid = 1'b0;
        end
    end

    // ==========================================================
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st       <= '0;
            st.sel_n <= 1'b1;
            st.ctype <= pml_pkg::PML_WORD_READ_CYCLE;
        end else begin
            st <= next_st;
        end
    end

    assign link.memory_selected_out_n = st.sel_n;
    assign cycle_valid_o   = st.valid;
    assign cycle_addr_o    = st.addr;
    assign cycle_io_page_o = st.iop;
    assign cycle_type_o    = st.ctype;
    assign byte_high_o     = st.addr[0];
endmodule
`default_nettype wire

// ### verilog/pml_master_end.sv
`timescale 1ns/1ps
`default_nettype none
`include "pml_consts.svh"

// Master end: address phase then strobe, or fallback to shared bus.
module pml_master_end (
    input  wire logic            sys_clk_i,
    input  wire logic            arst_n_i,
    pml_link_if.master           link,
    input  wire logic            req_i,
    input  wire logic [15:0]     req_addr_i,
    input  wire logic            req_io_page_i,
    input  wire pml_pkg::pml_cycle_t req_type_i,
    input  wire logic            bus_sync_busy_i,
    output logic                 busy_o,
    output logic                 link_cycle_o,
    output logic                 fallback_o
);
    typedef enum logic [2:0] {
        PML_M_IDLE  = 3'h0,
        PML_M_ADDR  = 3'h1,
        PML_M_STRB  = 3'h2,
        PML_M_HOLD  = 3'h3,
        PML_M_DATA  = 3'h4
    } pml_mst_t;

    typedef struct packed {
        pml_mst_t    state;
        logic [1:0]  sel_sync;
        logic [1:0]  alt_sync;
        logic [1:0]  rply_sync;
        logic [3:0]  cnt;
        logic [15:0] addr;
        logic        addr_oe_n;
        logic        iop_n;
        logic [1:0]  enc;
        logic        strobe_n;
        logic        busy;
        logic        link_cyc;
        logic        fallback;
    } pml_mst_st_t;

    pml_mst_st_t st;
    pml_mst_st_t next_st;

    // Encoding onto write-byte / byte-select lines
    function automatic logic [1:0] pml_encode(input pml_pkg::pml_cycle_t t);
        pml_encode = `PML_ENC_RD;
        case (t)
            pml_pkg::PML_READ_PAUSE_CYCLE: pml_encode = `PML_ENC_RDP;
            pml_pkg::PML_WORD_WRITE_CYCLE: pml_encode = `PML_ENC_WR;
            pml_pkg::PML_BYTE_WRITE_CYCLE: pml_encode = `PML_ENC_WRB;
            default:                       pml_encode = `PML_ENC_RD;
        endcase
    endfunction

    // ==========================================================
    // Sequencer; single cycles only, never block mode
    always_comb begin
        next_st = st;
        next_st.sel_sync  = {st.sel_sync[0], ~link.memory_selected_out_n};
        next_st.alt_sync  = {st.alt_sync[0], ~link.alt_bus_memory_responding_n};
        next_st.rply_sync = {st.rply_sync[0], ~link.bus_reply_in_n};
        next_st.fallback  = 1'b0;
        next_st.link_cyc  = 1'b0;
        case (st.state)
            PML_M_IDLE: begin
                // Wait for earlier sync and reply to clear, and for the last
                // cycle's select to fall so a stale one is not taken as fresh
                if (req_i && !bus_sync_busy_i && !st.rply_sync[1] && !st.sel_sync[1]) begin
                    next_st.addr      = req_addr_i;
                    next_st.addr_oe_n = 1'b0;
                    next_st.iop_n     = ~req_io_page_i;
                    next_st.enc       = pml_encode(req_type_i);
                    next_st.busy      = 1'b1;
                    next_st.cnt       = `PML_SEL_WAIT;
                    next_st.state     = PML_M_ADDR;
                end
            end
            PML_M_ADDR: begin
                if (st.sel_sync[1] && !st.alt_sync[1]) begin
                    next_st.strobe_n = 1'b0;
                    next_st.cnt      = 4'(`PML_HOLD_CYC);
                    next_st.state    = PML_M_HOLD;
                end else if (st.cnt == `PML_CNT_ZERO) begin
                    next_st.fallback  = 1'b1;
                    next_st.addr_oe_n = 1'b1;
                    next_st.iop_n     = 1'b1;
                    next_st.enc       = `PML_ENC_RD;
                    next_st.busy      = 1'b0;
                    next_st.state     = PML_M_IDLE;
                end else begin
                    next_st.cnt = st.cnt - `PML_CNT_ONE;
                end
            end
            PML_M_HOLD: begin
                // Keep lines a short time past strobe, then release
                if (st.cnt <= `PML_CNT_ONE) begin
                    next_st.addr_oe_n = 1'b1;
                    next_st.iop_n     = 1'b1;
                    next_st.enc       = `PML_ENC_RD;
                    next_st.state     = PML_M_STRB;
                end else begin
                    next_st.cnt = st.cnt - `PML_CNT_ONE;
                end
            end
            PML_M_STRB: begin
                if (!st.sel_sync[1]) begin
                    next_st.strobe_n = 1'b1;
                    next_st.fallback = 1'b1;
                    next_st.busy     = 1'b0;
                    next_st.state    = PML_M_IDLE;
                end else begin
                    next_st.link_cyc = 1'b1;
                    next_st.state    = PML_M_DATA;
                end
            end
            PML_M_DATA: begin
                // Data phase lies elsewhere; end the link cycle here
                next_st.strobe_n = 1'b1;
                next_st.busy     = 1'b0;
                next_st.state    = PML_M_IDLE;
            end
            default: begin
                next_st.state = PML_M_IDLE;
            end
        endcase
    end

    // ==========================================================
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st           <= '0;
            st.addr_oe_n <= 1'b1;
            st.iop_n     <= 1'b1;
            st.enc       <= `PML_ENC_RD;
            st.strobe_n  <= 1'b1;
            st.state     <= PML_M_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign link.dal_m               = st.addr;
    assign link.dal_m_oe_n          = st.addr_oe_n;
    assign link.io_page_select_n    = st.iop_n;
    assign link.write_byte_line_n   = st.enc[1];
    assign link.link_byte_select_n  = st.enc[0];
    assign link.link_cycle_strobe_n = st.strobe_n;
    // Shared-bus cycles, and other masters' block transfers, run elsewhere
    assign link.bus_sync_out_n      = 1'b1;
    assign busy_o       = st.busy;
    assign link_cycle_o = st.link_cyc;
    assign fallback_o   = st.fallback;
endmodule
`default_nettype wire

// ### dv/pml_link_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// Address-phase, strobe and bus-sync checks on the link wires
module pml_link_asserts #(
    parameter logic [15:0] BASE_PAGE = 16'h0000
) (
    input wire logic        sys_clk_i,
    input wire logic        arst_n_i,
    input wire logic [15:0] dal_m,
    input wire logic        dal_m_oe_n,
    input wire logic        io_page_select_n,
    input wire logic        write_byte_line_n,
    input wire logic        link_byte_select_n,
    input wire logic        link_cycle_strobe_n,
    input wire logic        bus_sync_out_n,
    input wire logic        bus_reply_in_n,
    input wire logic        memory_selected_out_n,
    input wire logic        alt_bus_memory_responding_n
);
    logic [1:0] page;

    // Page field of the address, for the select decode
    assign page = dal_m[15:14];
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!arst_n_i);
    // Memory latches at the strobe, so the lines must outlive it
    sequence s_held;
        (!dal_m_oe_n && $stable(dal_m) && $stable(write_byte_line_n))[*2];
    endsequence
    sequence s_gone;
        dal_m_oe_n;
    endsequence
    AST_HOLD: assert property ($fell(link_cycle_strobe_n) |-> s_held ##1 s_gone)
        else $error("link lines not held two cycles past strobe");
    AST_ADDR_FIRST: assert property ($fell(link_cycle_strobe_n) |-> $past(dal_m_oe_n, 2) == 1'b0)
        else $error("strobe without address driven first");
    AST_SEL_MATCH: assert property ($fell(memory_selected_out_n) |->
        $past(dal_m_oe_n, 2) == 1'b0 && $past(page, 2) == BASE_PAGE[15:14])
        else $error("select without a matching address");
    AST_NO_SEL: assert property ((dal_m_oe_n && link_cycle_strobe_n)[*6] |-> memory_selected_out_n)
        else $error("select held with the link idle");
    AST_PROCEED: assert property ($fell(link_cycle_strobe_n) |->
        $past(memory_selected_out_n, 2) == 1'b0 && $past(alt_bus_memory_responding_n, 2))
        else $error("strobe without select or with other memory answering");
    AST_SYNC_IDLE: assert property (bus_sync_out_n)
        else $error("shared bus sync driven");
    AST_REPLY_FREE: assert property ($fell(dal_m_oe_n) |-> $past(bus_reply_in_n, 3))
        else $error("cycle started while reply stood");
    AST_ENC_STEADY: assert property (!dal_m_oe_n && $past(dal_m_oe_n) == 1'b0 |->
        $stable({write_byte_line_n, link_byte_select_n}) && $stable(io_page_select_n))
        else $error("type or page lines moved during address phase");
    AST_STROBE_END: assert property ($fell(link_cycle_strobe_n) |-> ##[1:8] link_cycle_strobe_n)
        else $error("strobe never released");
endmodule
`default_nettype wire

// ### dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "pml_consts.svh"
// ==================================================
// Master end facing memory end across the link
module testbench;
    logic                sys_clk_i;
    logic                arst_n_i;
    logic                req_i;
    logic [15:0]         req_addr_i;
    logic                req_io_page_i;
    pml_pkg::pml_cycle_t req_type_i;
    logic                bus_sync_busy_i;
    logic                busy_o;
    logic                link_cycle_o;
    logic                fallback_o;
    logic                cycle_valid_o;
    logic [15:0]         cycle_addr_o;
    logic                cycle_io_page_o;
    pml_pkg::pml_cycle_t cycle_type_o;
    logic                byte_high_o;
    int                  n_errors;
    int                  cmp_count;

    pml_link_if pml_link_if_i ();
    pml_master_end pml_master_end_i (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .link(pml_link_if_i.master),
        .req_i(req_i), .req_addr_i(req_addr_i), .req_io_page_i(req_io_page_i), .req_type_i(req_type_i),
        .bus_sync_busy_i(bus_sync_busy_i), .busy_o(busy_o), .link_cycle_o(link_cycle_o), .fallback_o(fallback_o));
    pml_memory_end #(.BASE_PAGE(16'h4000)) pml_memory_end_i (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
        .link(pml_link_if_i.memory), .cycle_valid_o(cycle_valid_o), .cycle_addr_o(cycle_addr_o),
        .cycle_io_page_o(cycle_io_page_o), .cycle_type_o(cycle_type_o), .byte_high_o(byte_high_o));
    pml_link_asserts #(.BASE_PAGE(16'h4000)) pml_link_asserts_i (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
        .dal_m(pml_link_if_i.dal_m), .dal_m_oe_n(pml_link_if_i.dal_m_oe_n),
        .io_page_select_n(pml_link_if_i.io_page_select_n), .write_byte_line_n(pml_link_if_i.write_byte_line_n),
        .link_byte_select_n(pml_link_if_i.link_byte_select_n),
        .link_cycle_strobe_n(pml_link_if_i.link_cycle_strobe_n), .bus_sync_out_n(pml_link_if_i.bus_sync_out_n),
        .bus_reply_in_n(pml_link_if_i.bus_reply_in_n), .memory_selected_out_n(pml_link_if_i.memory_selected_out_n),
        .alt_bus_memory_responding_n(pml_link_if_i.alt_bus_memory_responding_n));

    // 40 MHz clock
    initial begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("compares %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // One request; a sync-busy or reply blocker in force is lifted after ten cycles
    task automatic run(input logic [15:0] a, input logic iop, input pml_pkg::pml_cycle_t t,
                       input logic [1:0] enc, input logic exp_link, input logic blocked);
        int   first = 99;
        logic got_l = 1'b0, got_f = 1'b0, got_s = 1'b0, got_v = 1'b0;
        @(posedge sys_clk_i);
        req_i <= 1'b1;
        req_addr_i <= a;
        req_io_page_i <= iop;
        req_type_i <= t;
        for (int n = 0; n < 30; n++) begin
            @(posedge sys_clk_i);
            if (n == 10) begin
                bus_sync_busy_i <= 1'b0;
                pml_link_if_i.bus_reply_in_n <= 1'b1;
            end
            if (first < 99) begin
                req_i <= 1'b0;
            end
            #1;
            if (busy_o === 1'b1 && first == 99) begin
                first = n;
            end
            if (pml_link_if_i.link_cycle_strobe_n === 1'b0 && !got_s) begin
                got_s = 1'b1;
                check({pml_link_if_i.write_byte_line_n, pml_link_if_i.link_byte_select_n}, enc, "type code");
                check(pml_link_if_i.dal_m, a, "address");
                check(pml_link_if_i.io_page_select_n, !iop, "page select");
            end
            // First capture only: a stale one would hide a missed update
            if (cycle_valid_o === 1'b1 && !got_v) begin
                got_v = 1'b1;
                check(cycle_addr_o, a, "captured address");
                check({cycle_io_page_o, byte_high_o}, {iop, a[0]}, "captured page and byte");
                check(cycle_type_o, t, "captured type");
            end
            got_l |= (link_cycle_o === 1'b1);
            got_f |= (fallback_o === 1'b1);
        end
        check(first >= 10, blocked, "start held off");
        check({got_l, got_f, got_v}, {exp_link, !exp_link, exp_link}, "outcome");
        if (!got_l && !got_f) begin
            stop_test();
        end
    endtask

    // Main sequence
    initial begin
        n_errors = 0;
        cmp_count = 0;
        arst_n_i = 1'b0;
        req_i = 1'b0;
        req_addr_i = 16'h0000;
        req_io_page_i = 1'b0;
        req_type_i = pml_pkg::PML_WORD_READ_CYCLE;
        bus_sync_busy_i = 1'b0;
        pml_link_if_i.bus_reply_in_n = 1'b1;
        pml_link_if_i.alt_bus_memory_responding_n = 1'b1;
        repeat (3) @(posedge sys_clk_i);
        arst_n_i <= 1'b1;
        // Every cycle type back to back, one in the I/O page, odd byte last
        run(16'h4002, 1'b0, pml_pkg::PML_WORD_READ_CYCLE, `PML_ENC_RD, 1'b1, 1'b0);
        run(16'h7FFE, 1'b1, pml_pkg::PML_READ_PAUSE_CYCLE, `PML_ENC_RDP, 1'b1, 1'b0);
        run(16'h4ABC, 1'b0, pml_pkg::PML_WORD_WRITE_CYCLE, `PML_ENC_WR, 1'b1, 1'b0);
        run(16'h5001, 1'b0, pml_pkg::PML_BYTE_WRITE_CYCLE, `PML_ENC_WRB, 1'b1, 1'b0);
        // Address outside this memory: no select, so the master falls back
        run(16'h8000, 1'b0, pml_pkg::PML_WORD_READ_CYCLE, `PML_ENC_RD, 1'b0, 1'b0);
        // Other bus memory answering: the master must not proceed
        @(posedge sys_clk_i);
        pml_link_if_i.alt_bus_memory_responding_n <= 1'b0;
        run(16'h4010, 1'b0, pml_pkg::PML_WORD_WRITE_CYCLE, `PML_ENC_WR, 1'b0, 1'b0);
        @(posedge sys_clk_i);
        pml_link_if_i.alt_bus_memory_responding_n <= 1'b1;
        // Shared bus busy, then a standing reply: start waits for both
        bus_sync_busy_i <= 1'b1;
        run(16'h4100, 1'b0, pml_pkg::PML_WORD_READ_CYCLE, `PML_ENC_RD, 1'b1, 1'b1);
        @(posedge sys_clk_i);
        pml_link_if_i.bus_reply_in_n <= 1'b0;
        // The master sees the reply only after its two sync flops
        repeat (3) @(posedge sys_clk_i);
        run(16'h4200, 1'b1, pml_pkg::PML_BYTE_WRITE_CYCLE, `PML_ENC_WRB, 1'b1, 1'b1);
        stop_test();
    end
endmodule
`default_nettype wire
